/* File: inc/rss_pkg.sv */
// constants, opcodes and register map of the rotate/subtract/sleep core
package rss_pkg;

    // register byte offsets
    localparam logic [7:0] RSS_CMD_OFS    = 8'h00;
    localparam logic [7:0] RSS_ACC_OFS    = 8'h04;
    localparam logic [7:0] RSS_STATUS_OFS = 8'h08;
    localparam logic [7:0] RSS_WDG_OFS    = 8'h0C;
    localparam logic [7:0] RSS_FIDX_OFS   = 8'h10;
    localparam logic [7:0] RSS_FDATA_OFS  = 8'h14;

    // command word fields
    localparam int RSS_CMD_OP_LSB   = 0;
    localparam int RSS_CMD_DEST_BIT = 3;
    localparam int RSS_CMD_ADR_LSB  = 4;
    localparam int RSS_CMD_LIT_LSB  = 16;

    // status word fields
    localparam int RSS_ST_C   = 0;
    localparam int RSS_ST_DGC = 1;
    localparam int RSS_ST_Z   = 2;
    localparam int RSS_ST_PDN = 3;
    localparam int RSS_ST_TON = 4;

    // watchdog word fields
    localparam int RSS_WDG_CNT_LSB = 0;
    localparam int RSS_WDG_PRE_LSB = 8;

    // reset and load values
    localparam logic [7:0] RSS_ACC_RST   = 8'h00;
    localparam logic [7:0] RSS_WDG_CLEAR = 8'h00;
    localparam logic [7:0] RSS_PRE_CLEAR = 8'h00;
    localparam logic       RSS_PDN_RST   = 1'b1;
    localparam logic       RSS_TON_RST   = 1'b1;

    // destination select
    localparam logic RSS_DEST_ACC  = 1'b0;
    localparam logic RSS_DEST_FILE = 1'b1;

    typedef enum logic [2:0] {
        OP_NOP,
        ROTATE_RIGHT_CARRY_OP,
        SUB_ACC_FROM_FILE_OP,
        SUB_ACC_FROM_LITERAL_OP,
        SUB_WITH_BORROW_OP,
        NIBBLE_SWAP_OP,
        POWERDOWN_OP
    } rss_op_t;

endpackage

/* File: inc/rss_alu_if.sv */
// operands and results between the core and its arithmetic unit
`timescale 1ns/1ns
interface rss_alu_if;
    import rss_pkg::*;
    rss_op_t    op;
    logic [7:0] file_val;
    logic [7:0] acc_val;
    logic [7:0] literal;
    logic       carry_in;
    logic [7:0] result;
    logic       carry_out;
    logic       dgc_out;
    logic       zero_out;
    logic       upd_c;
    logic       upd_dgc;
    logic       upd_z;
    logic       force_acc;

    modport core (
        output op, file_val, acc_val, literal, carry_in,
        input  result, carry_out, dgc_out, zero_out,
        input  upd_c, upd_dgc, upd_z, force_acc
    );
    modport alu (
        input  op, file_val, acc_val, literal, carry_in,
        output result, carry_out, dgc_out, zero_out,
        output upd_c, upd_dgc, upd_z, force_acc
    );
endinterface

/* File: src/rss_alu.sv */
// combinational arithmetic unit for rotate, subtract and swap
`timescale 1ns/1ns
module rss_alu
    import rss_pkg::*;
(
    rss_alu_if.alu a
);
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] minuend;
    logic       cin;

    always_comb begin
        minuend     = (a.op == SUB_ACC_FROM_LITERAL_OP) ? a.literal
                                                         : a.file_val;
        // borrow-in is the inverted carry only for the borrow form
        cin         = (a.op == SUB_WITH_BORROW_OP) ? a.carry_in : 1'b1;
        sum         = {1'b0, minuend} + {1'b0, ~a.acc_val} + {8'h00, cin};
        nib         = {1'b0, minuend[3:0]} + {1'b0, ~a.acc_val[3:0]}
                    + {4'h0, cin};
        a.result    = a.file_val;
        a.carry_out = a.carry_in;
        a.dgc_out   = 1'b0;
        a.zero_out  = 1'b0;
        a.upd_c     = 1'b0;
        a.upd_dgc   = 1'b0;
        a.upd_z     = 1'b0;
        a.force_acc = 1'b0;
        case (a.op)
            ROTATE_RIGHT_CARRY_OP: begin
                a.result    = {a.carry_in, a.file_val[7:1]};
                a.carry_out = a.file_val[0];
                a.upd_c     = 1'b1;
            end
            SUB_ACC_FROM_FILE_OP,
            SUB_ACC_FROM_LITERAL_OP,
            SUB_WITH_BORROW_OP: begin
                a.result    = sum[7:0];
                a.carry_out = sum[8];
                a.dgc_out   = nib[4];
                a.zero_out  = (sum[7:0] == 8'h00);
                a.upd_c     = 1'b1;
                a.upd_dgc   = 1'b1;
                a.upd_z     = 1'b1;
                a.force_acc = (a.op == SUB_ACC_FROM_LITERAL_OP);
            end
            NIBBLE_SWAP_OP: begin
                a.result = {a.file_val[3:0], a.file_val[7:4]};
            end
            default: begin
                a.result = a.file_val;
            end
        endcase
    end
endmodule

/* File: src/rss_core.sv */
// accumulator core subset with watchdog, behind a wishbone slave
`timescale 1ns/1ns

module rss_core
    import rss_pkg::*;
#(
    parameter int FILE_DEPTH = 128,
    parameter int PRE_WIDTH  = 8
) (
    // clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RESET_N,
    // wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O
);
    typedef struct packed {
        logic                             ack;
        logic [31:0]                      rdata;
        logic [7:0]                       acc;
        logic                             c;
        logic                             digit_carry;
        logic                             z;
        logic                             powerdown_flag_n;
        logic                             timeout_flag_n;
        logic [7:0]                       watchdog_counter;
        logic [PRE_WIDTH-1:0]             presc;
        logic [6:0]                       fidx;
        logic [FILE_DEPTH-1:0][7:0]       file;
    } rss_state_t;

    rss_state_t st_reg;
    rss_state_t st_next;

    rss_alu_if alu_bus ();

    rss_alu u_alu (
        .a (alu_bus.alu)
    );

    logic       req;
    logic       wr_fire;
    rss_op_t    cmd_op;
    logic       cmd_dest;
    logic [6:0] cmd_adr;
    logic [7:0] cmd_lit;
    logic       cmd_go;
    logic [31:0] rd_mux;

    assign req      = WB_CYC_I & WB_STB_I;
    // writes land on the edge where ack is seen high
    assign wr_fire  = req & WB_WE_I & st_reg.ack;
    assign cmd_op   = rss_op_t'(WB_DAT_I[RSS_CMD_OP_LSB +: 3]);
    assign cmd_dest = WB_DAT_I[RSS_CMD_DEST_BIT];
    assign cmd_adr  = WB_DAT_I[RSS_CMD_ADR_LSB +: 7];
    assign cmd_lit  = WB_DAT_I[RSS_CMD_LIT_LSB +: 8];
    assign cmd_go   = wr_fire && (WB_ADR_I == RSS_CMD_OFS)
                    && (WB_SEL_I[2:0] == 3'b111);

    // operand routing to the arithmetic unit
    assign alu_bus.op       = cmd_go ? cmd_op : OP_NOP;
    assign alu_bus.file_val = st_reg.file[cmd_adr];
    assign alu_bus.acc_val  = st_reg.acc;
    assign alu_bus.literal  = cmd_lit;
    assign alu_bus.carry_in = st_reg.c;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (WB_ADR_I)
            RSS_ACC_OFS: begin
                rd_mux[7:0] = st_reg.acc;
            end
            RSS_STATUS_OFS: begin
                rd_mux[RSS_ST_C]   = st_reg.c;
                rd_mux[RSS_ST_DGC] = st_reg.digit_carry;
                rd_mux[RSS_ST_Z]   = st_reg.z;
                rd_mux[RSS_ST_PDN] = st_reg.powerdown_flag_n;
                rd_mux[RSS_ST_TON] = st_reg.timeout_flag_n;
            end
            RSS_WDG_OFS: begin
                rd_mux[RSS_WDG_CNT_LSB +: 8]         = st_reg.watchdog_counter;
                rd_mux[RSS_WDG_PRE_LSB +: PRE_WIDTH] = st_reg.presc;
            end
            RSS_FIDX_OFS: begin
                rd_mux[6:0] = st_reg.fidx;
            end
            RSS_FDATA_OFS: begin
                rd_mux[7:0] = st_reg.file[st_reg.fidx];
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        st_next = st_reg;

        // one-cycle answer, dropped the cycle after
        st_next.ack = req & ~st_reg.ack;
        if (req && !st_reg.ack && !WB_WE_I) begin
            st_next.rdata = rd_mux;
        end

        // free-running watchdog: prescaler then counter
        st_next.presc = st_reg.presc + 1'b1;
        if (&st_reg.presc) begin
            st_next.watchdog_counter = st_reg.watchdog_counter + 8'h01;
        end

        if (wr_fire && WB_SEL_I[0]) begin
            case (WB_ADR_I)
                RSS_ACC_OFS: begin
                    st_next.acc = WB_DAT_I[7:0];
                end
                RSS_STATUS_OFS: begin
                    st_next.c           = WB_DAT_I[RSS_ST_C];
                    st_next.digit_carry = WB_DAT_I[RSS_ST_DGC];
                    st_next.z           = WB_DAT_I[RSS_ST_Z];
                end
                RSS_FIDX_OFS: begin
                    st_next.fidx = WB_DAT_I[6:0];
                end
                RSS_FDATA_OFS: begin
                    st_next.file[st_reg.fidx] = WB_DAT_I[7:0];
                end
                default: begin
                    st_next.fidx = st_reg.fidx;
                end
            endcase
        end

        if (cmd_go) begin
            if (cmd_op == POWERDOWN_OP) begin
                st_next.watchdog_counter = RSS_WDG_CLEAR;
                st_next.presc            = '0;
                st_next.powerdown_flag_n = 1'b0;
                st_next.timeout_flag_n   = 1'b1;
            end else if (cmd_op != OP_NOP) begin
                if (alu_bus.force_acc
                        || cmd_dest == RSS_DEST_ACC) begin
                    st_next.acc = alu_bus.result;
                end else begin
                    st_next.file[cmd_adr] = alu_bus.result;
                end
                if (alu_bus.upd_c) begin
                    st_next.c = alu_bus.carry_out;
                end
                if (alu_bus.upd_dgc) begin
                    st_next.digit_carry = alu_bus.dgc_out;
                end
                if (alu_bus.upd_z) begin
                    st_next.z = alu_bus.zero_out;
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            st_reg                  <= '0;
            st_reg.acc              <= RSS_ACC_RST;
            st_reg.watchdog_counter <= RSS_WDG_CLEAR;
            st_reg.powerdown_flag_n <= RSS_PDN_RST;
            st_reg.timeout_flag_n   <= RSS_TON_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign WB_DAT_O = st_reg.rdata;
    assign WB_ACK_O = st_reg.ack;
endmodule

/* File: dv/rss_core_assertions.sv */
// bus and status-flag checks for the rotate/subtract/sleep core
`timescale 1ns/1ns
module rss_core_assertions
    import rss_pkg::*;
(
    // clock and reset
    input wire logic        CLK_SYS,
    input wire logic        RESET_N,
    // wishbone
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [7:0]  WB_ADR_I,
    input wire logic [3:0]  WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O
);
    logic sleep_seen_reg;
    logic rd_ack;
    assign rd_ack = WB_ACK_O & ~WB_WE_I;
    // remembers an accepted power-down command
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            sleep_seen_reg <= 1'b0;
        end else if (WB_CYC_I && WB_STB_I && WB_ACK_O && WB_WE_I
                     && WB_ADR_I == RSS_CMD_OFS
                     && WB_SEL_I[2:0] == 3'b111
                     && WB_DAT_I[2:0] == POWERDOWN_OP) begin
            sleep_seen_reg <= 1'b1;
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);
    ack_follows_req_a:
    assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("ack missing after request");
    ack_one_cycle_a:
    assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
    ack_has_cause_a:
    assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
        else $error("ack without request");
    cmd_reads_zero_a:
    assert property (rd_ack && WB_ADR_I == RSS_CMD_OFS |-> WB_DAT_O == 0)
        else $error("command read not zero");
    unmapped_zero_a:
    assert property (rd_ack && WB_ADR_I > RSS_FDATA_OFS |-> WB_DAT_O == 0)
        else $error("unmapped read not zero");
    powerdown_flag_a:
    assert property (rd_ack && WB_ADR_I == RSS_STATUS_OFS
        |-> WB_DAT_O[RSS_ST_PDN] == !sleep_seen_reg)
        else $error("power-down flag wrong");
    to_flag_a:
    assert property (rd_ack && WB_ADR_I == RSS_STATUS_OFS
        |-> WB_DAT_O[RSS_ST_TON]) else $error("timeout flag low");
    acc_width_a:
    assert property (rd_ack && WB_ADR_I == RSS_ACC_OFS
        |-> WB_DAT_O[31:8] == 0) else $error("accumulator wider than 8");
    cover property (rd_ack && WB_ADR_I == RSS_STATUS_OFS && sleep_seen_reg);
    cover property (WB_ACK_O && WB_WE_I && WB_ADR_I == RSS_CMD_OFS);
    cover property (rd_ack && WB_ADR_I > RSS_FDATA_OFS);
endmodule
bind rss_core rss_core_assertions u_chk (.CLK_SYS(CLK_SYS),
    .RESET_N(RESET_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O));

/* File: dv/tb_top.sv */
// register-level testbench of the rotate/subtract/sleep core
`timescale 1ns/1ns
module tb_top
    import rss_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic        ack;
    logic [31:0] q;
    int          bad_count = 0;
    int          total_checks = 0;
    always #2 clk_sys = ~clk_sys;
    rss_core dut (.CLK_SYS(clk_sys), .RESET_N(reset_n), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // one classic cycle; held until the rising edge that sees ack high
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_sys);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hF};
        do begin
            @(negedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk(32'h0, 32'h1);
            wrap_up();
        end
        // ack stands up to this edge; data taken and request dropped here
        @(posedge clk_sys);
        r = rdat;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        wb(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask
    task automatic exe(input rss_op_t op, input logic d, input logic [6:0] a,
                       input logic [7:0] k);
        wr(RSS_CMD_OFS, {8'h00, k, 5'h00, a, d, op});
    endtask
    // sets file, acc and flags, runs one op, checks both places and flags
    task automatic run(input rss_op_t op, input logic d, input logic [6:0] a,
        input logic [7:0] f, input logic [7:0] w, input logic c,
        input logic [7:0] k);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] m;
        logic [7:0] r;
        logic [2:0] fl;
        logic       bo;
        logic       to_acc;
        m = (op == SUB_ACC_FROM_LITERAL_OP) ? k : f;
        // borrow only in the borrow form, when carry is clear
        bo = (op == SUB_WITH_BORROW_OP) && !c;
        // subtrahend plus borrow, held against the minuend
        s = {1'b0, w} + {8'h00, bo};
        h = {1'b0, w[3:0]} + {4'h0, bo};
        fl = {2'b11, c};
        case (op)
            ROTATE_RIGHT_CARRY_OP: begin
                r = {c, f[7:1]};
                fl = {2'b11, f[0]};
            end
            NIBBLE_SWAP_OP: r = {f[3:0], f[7:4]};
            default: begin
                r = m - w - {7'h00, bo};
                fl = {r == 8'h00, h <= {1'b0, m[3:0]}, s <= {1'b0, m}};
            end
        endcase
        to_acc = !d || op == SUB_ACC_FROM_LITERAL_OP;
        wr(RSS_FIDX_OFS, {25'h0, a});
        wr(RSS_FDATA_OFS, {24'h0, f});
        wr(RSS_ACC_OFS, {24'h0, w});
        wr(RSS_STATUS_OFS, {29'h0, 2'b11, c});
        exe(op, d, a, k);
        rc(RSS_ACC_OFS, {24'h0, to_acc ? r : w});
        wr(RSS_FIDX_OFS, {25'h0, a});
        rc(RSS_FDATA_OFS, {24'h0, to_acc ? f : r});
        rc(RSS_STATUS_OFS, {27'h0, 2'b11, fl});
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        rc(RSS_ACC_OFS, 32'h0000_0000);
        rc(RSS_STATUS_OFS, 32'h0000_0018);
        wr(8'h40, 32'hFFFF_FFFF);
        rc(8'h40, 32'h0000_0000);
        rc(RSS_CMD_OFS, 32'h0000_0000);
        $display("reset and map test done");
        run(ROTATE_RIGHT_CARRY_OP, 0, 7'd5, 8'hA5, 8'h33, 1, 0);
        run(ROTATE_RIGHT_CARRY_OP, 1, 7'd127, 8'h4C, 8'h00, 0, 0);
        run(SUB_ACC_FROM_FILE_OP, 1, 7'd9, 8'h35, 8'h12, 0, 0);
        run(SUB_ACC_FROM_FILE_OP, 0, 7'd0, 8'h12, 8'h35, 1, 0);
        run(SUB_ACC_FROM_FILE_OP, 1, 7'd3, 8'h10, 8'h01, 0, 0);
        run(SUB_ACC_FROM_FILE_OP, 0, 7'd4, 8'h44, 8'h44, 0, 0);
        run(SUB_ACC_FROM_LITERAL_OP, 1, 7'd2, 8'h00, 8'h21, 0,
            8'h20);
        run(SUB_ACC_FROM_LITERAL_OP, 0, 7'd2, 8'h00, 8'h0F, 0,
            8'hFF);
        run(SUB_WITH_BORROW_OP, 1, 7'd6, 8'h50, 8'h20, 0, 0);
        run(SUB_WITH_BORROW_OP, 0, 7'd6, 8'h50, 8'h50, 1, 0);
        run(SUB_WITH_BORROW_OP, 1, 7'd7, 8'h00, 8'h00, 0, 0);
        run(NIBBLE_SWAP_OP, 0, 7'd8, 8'h3C, 8'h99, 1, 0);
        run(NIBBLE_SWAP_OP, 1, 7'd126, 8'hF0, 8'h00, 0, 0);
        $display("operation test done");
        wr(RSS_STATUS_OFS, 32'h0000_0005);
        repeat (600) @(posedge clk_sys);
        exe(POWERDOWN_OP, 0, 7'd0, 0);
        wb(1'b0, RSS_WDG_OFS, 32'h0, q);
        chk({24'h0, q[7:0]}, 32'h0000_0000);
        chk({31'h0, q[15:8] < 8'd16}, 32'h0000_0001);
        rc(RSS_STATUS_OFS, 32'h0000_0015);
        $display("power-down test done");
        wrap_up();
    end
    initial begin
        #200000;
        bad_count++;
        wrap_up();
    end
endmodule
